/* File: hdl/pac_cmp.sv */
/*
  One PIN comparator: exact equality on all four BCD digits.
  Assumes both operands are registered in the same clock domain.
*/
module pac_cmp
  import pac_pkg::*;
#(
  parameter int DIGITS = PAC_DIGITS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Operands
  input wire logic [4*DIGITS-1:0] entered,
  input wire logic [4*DIGITS-1:0] stored,
  // Result
  output logic match
);
  logic match_reg;
  logic match_next;
  logic [DIGITS-1:0] digit_eq;

  genvar g;
  generate
    for (g = 0; g < DIGITS; g++)
    begin : g_dig
      assign digit_eq[g] = entered[4*g +: 4] == stored[4*g +: 4]; // [R14]
    end
  endgenerate

  always_comb
  begin
    match_next = &digit_eq; // [R14]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      match_reg <= 1'b0;
    else
      match_reg <= match_next;
  end

  assign match = match_reg;
endmodule // pac_cmp

/* File: hdl/pac_gate.sv */
/*
  PIN access gate: holds two stored PINs and the entered PIN, grants a
  level to the keypad and web sides, and lets the register bus pass.
  Assumes user and bus requests are synchronous one-cycle pulses.
*/
// Notes on behaviour
// [R1] Two levels exist, read-only and read/write, each with its own PIN.
// [R2] Entered PIN returns to 0000 at reset and at session time-out.
// [R3] Both stored PINs reset to 0000.
// [R4] A read/write match grants read/write whatever the read-only PIN is.
// [R5] With no matching PIN the keypad and web get no data.
// [R6] Read-only level may view but every change is refused.
// [R7] Read/write level may write configuration and change PINs.
// [R8] Register bus accesses skip every PIN check.
// [R9] Stored PINs read back over the bus only in encoded form.
// [R10] The keypad can never change a stored PIN.
// [R11] The web may set the read-only PIN only after a read/write match.
// [R12] Bus PIN writes are not checked against each other.
// [R13] The configuration tool path reads and writes with no PIN.
// [R14] PINs are four BCD digits compared for exact equality.
module pac_gate
  import pac_pkg::*;
#(
  parameter int TIMEOUT_CYC = PAC_TIMEOUT_CYC
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // PIN entry
  input wire logic PIN_ENTER,
  input wire logic [15:0] PIN_VALUE,
  // Keypad and web requests
  input wire pac_req_type KEY_REQ,
  input wire pac_req_type WEB_REQ,
  // Register bus and configuration tool
  input wire pac_bus_type BUS_REQ,
  input wire pac_bus_type TOOL_REQ,
  // Data source
  input wire logic [15:0] CFG_RDATA,
  // Results
  output pac_level_type LEVEL,
  output logic USER_GRANT,
  output logic USER_DENY,
  output logic [15:0] USER_RDATA,
  output logic CFG_WE,
  output logic [15:0] CFG_WDATA,
  output logic [15:0] BUS_RDATA,
  output logic BUS_ACK
);
  pac_state_type state_reg, state_next;
  logic [15:0] pin_ro_reg, pin_ro_next;
  logic [15:0] pin_rw_reg, pin_rw_next;
  logic [15:0] entered_reg, entered_next;
  logic [PAC_TMR_W-1:0] tmr_reg, tmr_next;
  logic grant_reg, grant_next;
  logic deny_reg, deny_next;
  logic [15:0] urd_reg, urd_next;
  logic cwe_reg, cwe_next;
  logic [15:0] cwd_reg, cwd_next;
  logic [15:0] brd_reg, brd_next;
  logic back_reg, back_next;
  logic match_ro, match_rw;
  logic cmp_hold_reg, cmp_hold_next;
  pac_level_type lvl;
  pac_req_type req;

  pac_cmp #(.DIGITS(PAC_DIGITS)) u_cmp_ro
  (
    .clk(SYS_CLK),
    .rst(RST),
    .entered(entered_reg),
    .stored(pin_ro_reg),
    .match(match_ro)
  );

  pac_cmp #(.DIGITS(PAC_DIGITS)) u_cmp_rw
  (
    .clk(SYS_CLK),
    .rst(RST),
    .entered(entered_reg),
    .stored(pin_rw_reg),
    .match(match_rw)
  );

  // Level is valid once the comparators settle after a change
  always_comb
  begin
    if (cmp_hold_reg)
      lvl = PAC_LVL_NONE;
    else if (match_rw)
      lvl = PAC_LVL_RW; // [R4] [R1]
    else if (match_ro)
      lvl = PAC_LVL_RO; // [R1]
    else
      lvl = PAC_LVL_NONE;
    req = WEB_REQ.valid ? WEB_REQ : KEY_REQ;
  end

  always_comb
  begin
    state_next = state_reg;
    pin_ro_next = pin_ro_reg;
    pin_rw_next = pin_rw_reg;
    entered_next = entered_reg;
    tmr_next = tmr_reg;
    grant_next = 1'b0;
    deny_next = 1'b0;
    urd_next = urd_reg;
    cwe_next = 1'b0;
    cwd_next = cwd_reg;
    brd_next = brd_reg;
    back_next = 1'b0;
    case (state_reg)
      PAC_ST_IDLE:
      begin
        if (PIN_ENTER)
        begin
          entered_next = PIN_VALUE;
          tmr_next = '0;
          state_next = PAC_ST_SESSION;
        end
      end
      PAC_ST_SESSION:
      begin
        if (PIN_ENTER)
        begin
          entered_next = PIN_VALUE;
          tmr_next = '0;
        end
        else if (req.valid)
          tmr_next = '0;
        else if (tmr_reg >= PAC_TMR_W'(TIMEOUT_CYC - 1))
          state_next = PAC_ST_EXPIRE;
        else
          tmr_next = tmr_reg + 1'b1;
      end
      PAC_ST_EXPIRE:
      begin
        entered_next = PAC_PIN_DEFAULT; // [R2]
        state_next = PAC_ST_IDLE;
      end
      default:
        state_next = PAC_ST_IDLE;
    endcase
    // User side access, gated by level
    if (req.valid)
    begin
      if (lvl == PAC_LVL_NONE)
        deny_next = 1'b1; // [R5]
      else if (!req.is_write)
      begin
        grant_next = 1'b1;
        urd_next = CFG_RDATA;
      end
      else if (lvl != PAC_LVL_RW)
        deny_next = 1'b1; // [R6]
      else if (req.is_pin && !WEB_REQ.valid)
        deny_next = 1'b1; // [R10]
      else if (req.is_pin)
      begin
        grant_next = 1'b1; // [R7] [R11]
        if (req.pin_sel_rw)
          pin_rw_next = req.data;
        else
          pin_ro_next = req.data;
      end
      else
      begin
        grant_next = 1'b1; // [R7]
        cwe_next = 1'b1;
        cwd_next = req.data;
      end
    end
    // Bus and tool pass with no PIN check
    if (BUS_REQ.valid || TOOL_REQ.valid)
    begin
      back_next = 1'b1; // [R8] [R13]
      if (BUS_REQ.valid && BUS_REQ.is_write)
      begin
        if (BUS_REQ.pin_sel_rw)
          pin_rw_next = BUS_REQ.data; // [R12]
        else
          pin_ro_next = BUS_REQ.data; // [R12]
      end
      else if (BUS_REQ.valid)
        brd_next = (BUS_REQ.pin_sel_rw ? pin_rw_reg : pin_ro_reg)
          ^ PAC_ENC_KEY; // [R9]
      else if (TOOL_REQ.is_write)
      begin
        cwe_next = 1'b1; // [R13]
        cwd_next = TOOL_REQ.data;
      end
      else
        brd_next = CFG_RDATA; // [R13]
    end
    // A changed operand holds the level at none while compares settle
    cmp_hold_next = (entered_next != entered_reg)
      || (pin_ro_next != pin_ro_reg) || (pin_rw_next != pin_rw_reg);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_reg <= PAC_ST_IDLE;
      pin_ro_reg <= PAC_PIN_DEFAULT; // [R3]
      pin_rw_reg <= PAC_PIN_DEFAULT; // [R3]
      entered_reg <= PAC_PIN_DEFAULT; // [R2]
      tmr_reg <= '0;
      grant_reg <= 1'b0;
      deny_reg <= 1'b0;
      urd_reg <= 16'h0000;
      cwe_reg <= 1'b0;
      cwd_reg <= 16'h0000;
      brd_reg <= 16'h0000;
      back_reg <= 1'b0;
      cmp_hold_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      pin_ro_reg <= pin_ro_next;
      pin_rw_reg <= pin_rw_next;
      entered_reg <= entered_next;
      tmr_reg <= tmr_next;
      grant_reg <= grant_next;
      deny_reg <= deny_next;
      urd_reg <= urd_next;
      cwe_reg <= cwe_next;
      cwd_reg <= cwd_next;
      brd_reg <= brd_next;
      back_reg <= back_next;
      cmp_hold_reg <= cmp_hold_next;
    end
  end

  pac_level_type lvl_reg;
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      lvl_reg <= PAC_LVL_NONE;
    else
      lvl_reg <= lvl;
  end

  assign LEVEL = lvl_reg;
  assign USER_GRANT = grant_reg;
  assign USER_DENY = deny_reg;
  assign USER_RDATA = urd_reg;
  assign CFG_WE = cwe_reg;
  assign CFG_WDATA = cwd_reg;
  assign BUS_RDATA = brd_reg;
  assign BUS_ACK = back_reg;
endmodule // pac_gate

/* File: inc/pac_pkg.sv */
/*
  Package for the PIN access gate: PIN layout, defaults, timing, carriers.
  Assumes a single 100 MHz clock and synchronous active-high reset.
*/
package pac_pkg;
  localparam int PAC_DIGITS = 4;
  localparam int PAC_PIN_W = 4 * PAC_DIGITS;
  localparam logic [15:0] PAC_PIN_DEFAULT = 16'h0000;
  localparam logic [15:0] PAC_ENC_KEY = 16'hA5C3;
  localparam int PAC_CLK_MHZ = 100;
  localparam int PAC_TIMEOUT_MS = 60;
  localparam int PAC_TIMEOUT_CYC = PAC_TIMEOUT_MS * 1000 * PAC_CLK_MHZ;
  localparam int PAC_TMR_W = 32;

  typedef enum logic [1:0]
  {
    PAC_LVL_NONE = 2'h0,
    PAC_LVL_RO = 2'h1,
    PAC_LVL_RW = 2'h2
  } pac_level_type;

  typedef enum logic [2:0]
  {
    PAC_ST_IDLE = 3'h1,
    PAC_ST_SESSION = 3'h2,
    PAC_ST_EXPIRE = 3'h4
  } pac_state_type;

  // Request from a user-side interface
  typedef struct packed
  {
    logic valid;
    logic is_write;
    logic is_pin;
    logic pin_sel_rw;
    logic [15:0] data;
  } pac_req_type;

  // Register bus access that bypasses the gate
  typedef struct packed
  {
    logic valid;
    logic is_write;
    logic pin_sel_rw;
    logic [15:0] data;
  } pac_bus_type;
endpackage

/* File: tb/pac_gate_assertions.sv */
/*
  Checker on the ports of the PIN access gate.
  Assumes one clock and one-cycle registered answers.
*/
module pac_gate_assertions
  import pac_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Requests
  input wire pac_req_type KEY_REQ,
  input wire pac_req_type WEB_REQ,
  input wire pac_bus_type BUS_REQ,
  input wire pac_bus_type TOOL_REQ,
  input wire logic [15:0] CFG_RDATA,
  // Answers
  input wire pac_level_type LEVEL,
  input wire logic USER_GRANT,
  input wire logic USER_DENY,
  input wire logic [15:0] BUS_RDATA,
  input wire logic BUS_ACK
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  property p_rst;
    disable iff (1'h0)
    RST |=> LEVEL == PAC_LVL_NONE && !USER_GRANT && !BUS_ACK;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset");
  property p_ack;
    BUS_REQ.valid || TOOL_REQ.valid |=> BUS_ACK;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no ack");
  property p_tool;
    TOOL_REQ.valid && !TOOL_REQ.is_write && !BUS_REQ.valid
      |=> BUS_RDATA == $past(CFG_RDATA);
  endproperty
  a_tool: assert property (p_tool)
    else $error("tool read");
  // LEVEL shows one cycle later the level that judged a request
  property p_none;
    KEY_REQ.valid || WEB_REQ.valid
      |=> LEVEL != PAC_LVL_NONE || (USER_DENY && !USER_GRANT);
  endproperty
  a_none: assert property (p_none)
    else $error("no level");
  property p_ro;
    WEB_REQ.valid && WEB_REQ.is_write |=> LEVEL != PAC_LVL_RO || USER_DENY;
  endproperty
  a_ro: assert property (p_ro)
    else $error("ro write");
  property p_key;
    KEY_REQ.valid && KEY_REQ.is_pin && KEY_REQ.is_write && !WEB_REQ.valid
      |=> USER_DENY;
  endproperty
  a_key: assert property (p_key)
    else $error("keypad pin");
  property p_rw;
    WEB_REQ.valid && !WEB_REQ.is_pin |=> LEVEL != PAC_LVL_RW || USER_GRANT;
  endproperty
  a_rw: assert property (p_rw)
    else $error("rw denied");
  property p_ans;
    USER_GRANT || USER_DENY
      |-> !(USER_GRANT && USER_DENY) && $past(KEY_REQ.valid || WEB_REQ.valid);
  endproperty
  a_ans: assert property (p_ans)
    else $error("stray answer");
endmodule // pac_gate_assertions
bind pac_gate pac_gate_assertions i_chk (.SYS_CLK(SYS_CLK), .RST(RST),
  .KEY_REQ(KEY_REQ), .WEB_REQ(WEB_REQ), .BUS_REQ(BUS_REQ),
  .TOOL_REQ(TOOL_REQ), .CFG_RDATA(CFG_RDATA), .LEVEL(LEVEL),
  .USER_GRANT(USER_GRANT), .USER_DENY(USER_DENY),
  .BUS_RDATA(BUS_RDATA), .BUS_ACK(BUS_ACK));

/* File: tb/pac_gate_tb.sv */
/*
  Testbench for the PIN access gate.
  Assumes the user model and a 20-cycle session time-out.
*/
`define CHK(a, b) \
  compares++; \
  if ((a) !== (b)) \
  begin \
    num_errors++; \
    $display("ERROR %0t %h %h", $time, (a), (b)); \
  end
module pac_gate_tb
  import pac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO = 20;
  // Entered PIN, web/write/pin/rw-select, data, grant expected
  typedef struct packed
  {
    logic [15:0] pin;
    logic [3:0] ctl;
    logic [15:0] d;
    logic g;
  } pac_row_type;
  pac_row_type rows [7] = '{
    '{16'h5679, 4'h8, 16'h0000, 1'h0},
    '{16'h1234, 4'h8, 16'h0000, 1'h1},
    '{16'h1234, 4'hC, 16'h0000, 1'h0},
    '{16'h1234, 4'h4, 16'h0000, 1'h0},
    '{16'h5678, 4'hC, 16'h4321, 1'h1},
    '{16'h5678, 4'h7, 16'h9999, 1'h0},
    '{16'h5678, 4'hE, 16'h1111, 1'h1}};
  logic sys_clk, rst, pin_enter, grant, deny, cfg_we, bus_ack;
  logic [15:0] pin_value, cfg_rdata, user_rdata, cfg_wdata, bus_rdata;
  pac_req_type key_req, web_req;
  pac_bus_type bus_req, tool_req;
  pac_level_type level;
  int compares = 0;
  int num_errors = 0;
  pac_user u (.clk(sys_clk), .pin_enter(pin_enter), .pin_value(pin_value),
    .key_req(key_req), .web_req(web_req));
  pac_gate #(.TIMEOUT_CYC(TO)) i_pac_gate (.SYS_CLK(sys_clk), .RST(rst),
    .PIN_ENTER(pin_enter), .PIN_VALUE(pin_value), .KEY_REQ(key_req),
    .WEB_REQ(web_req), .BUS_REQ(bus_req), .TOOL_REQ(tool_req),
    .CFG_RDATA(cfg_rdata), .LEVEL(level), .USER_GRANT(grant),
    .USER_DENY(deny), .USER_RDATA(user_rdata), .CFG_WE(cfg_we),
    .CFG_WDATA(cfg_wdata), .BUS_RDATA(bus_rdata), .BUS_ACK(bus_ack));
  task automatic test_done;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait for a level
  task automatic wait_lvl(input pac_level_type l, input int n);
    while (level !== l && n > 0)
    begin
      @(posedge sys_clk);
      #1;
      n--;
    end
    `CHK(level, l)
    if (level !== l) test_done();
  endtask
  // One register bus or tool access
  task automatic bus(input logic t, w, s, input logic [15:0] d);
    pac_bus_type b;
    b = '{1'h1, w, s, d};
    @(posedge sys_clk);
    if (t) tool_req <= b;
    else bus_req <= b;
    @(posedge sys_clk);
    if (t) tool_req <= ~b;
    else bus_req <= ~b;
    #1;
  endtask
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    rst = 1'h1;
    bus_req = '0;
    tool_req = '0;
    cfg_rdata = 16'h9C3E;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    `CHK({level, bus_ack, grant}, {PAC_LVL_NONE, 2'h0})
    wait_lvl(PAC_LVL_RW, 6);
    bus(1'h0, 1'h0, 1'h1, 16'h0000);
    `CHK({bus_ack, bus_rdata}, {1'h1, PAC_PIN_DEFAULT ^ PAC_ENC_KEY})
    bus(1'h0, 1'h1, 1'h0, 16'h1234);
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(level, PAC_LVL_RW)
    bus(1'h0, 1'h1, 1'h1, 16'h5678);
    wait_lvl(PAC_LVL_NONE, 6);
    foreach (rows[i])
    begin
      pac_row_type r;
      logic [2:0] e;
      r = rows[i];
      e = {r.g, ~r.g, r.g & r.ctl[2] & ~r.ctl[1]};
      u.enter(r.pin);
      repeat (3) @(posedge sys_clk);
      u.req(r.ctl[3], pac_req_type'({1'h1, r.ctl[2:0], r.d}));
      #1;
      `CHK({grant, deny, cfg_we}, e)
    end
    `CHK({user_rdata, cfg_wdata}, {cfg_rdata, 16'h4321})
    bus(1'h0, 1'h0, 1'h0, 16'h0000);
    `CHK(bus_rdata, 16'h1111 ^ PAC_ENC_KEY)
    bus(1'h1, 1'h1, 1'h0, 16'h0BAD);
    `CHK({bus_ack, cfg_we, cfg_wdata}, {2'h3, 16'h0BAD})
    bus(1'h1, 1'h0, 1'h0, 16'h0000);
    `CHK({bus_ack, bus_rdata}, {1'h1, cfg_rdata})
    wait_lvl(PAC_LVL_NONE, TO + 8);
    // Reset in mid-run brings both stored PINs back to the default
    @(posedge sys_clk);
    rst <= 1'h1;
    @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    `CHK({level, bus_ack, grant}, {PAC_LVL_NONE, 2'h0})
    bus(1'h0, 1'h0, 1'h0, 16'h0000);
    `CHK(bus_rdata, PAC_PIN_DEFAULT ^ PAC_ENC_KEY)
    wait_lvl(PAC_LVL_RW, 6);
    test_done();
  end
endmodule // pac_gate_tb

/* File: tb/pac_user.sv */
/*
  User-side model: keypad and web PIN entry and requests.
  Assumes tasks are called by the bench off a clock edge.
*/
module pac_user
  import pac_pkg::*;
(
  // Clock
  input wire logic clk,
  // User side
  output logic pin_enter,
  output logic [15:0] pin_value,
  output pac_req_type key_req,
  output pac_req_type web_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    pin_enter = 1'h0;
    pin_value = 16'h0000;
    key_req = '0;
    web_req = '0;
  end
  // One PIN entry pulse
  task automatic enter(input logic [15:0] p);
    @(posedge clk);
    pin_enter <= 1'h1;
    pin_value <= p;
    @(posedge clk);
    pin_enter <= 1'h0;
    pin_value <= ~p;
  endtask
  // One request pulse; released fields show inverted values
  task automatic req(input logic web, input pac_req_type r);
    @(posedge clk);
    if (web) web_req <= r;
    else key_req <= r;
    @(posedge clk);
    if (web) web_req <= ~r;
    else key_req <= ~r;
  endtask
endmodule // pac_user
